// file: rtl/domc_consts.svh
`ifndef DOMC_CONSTS_SVH
`define DOMC_CONSTS_SVH
// Channel and direct input counts
`define DOMC_NCH 4
`define DOMC_NIN 2
// Input pin to channel placement in Limp Home (input 0 -> ch 2, input 1 -> ch 3)
`define DOMC_LH_CH_LO 2
// Mode transition time in ns, and clock period in ns
`define DOMC_T_TRANS_NS 32'd1000
`define DOMC_CLK_NS 32'd50
// Transition cycles, rounded up, zero for zero time
`define DOMC_TRANS_CYC ((`DOMC_T_TRANS_NS + `DOMC_CLK_NS - 32'd1) / `DOMC_CLK_NS)
// Mode code width and all-off channel value
`define DOMC_MODE_W 2
`define DOMC_CH_OFF 4'h0
`endif

// file: rtl/domc_pkg.sv
package domc_pkg;
   // Operating modes, Gray coded along sleep-idle-active-limp
   typedef enum logic [1:0] {
      DOMC_SLEEP  = 2'h0,
      DOMC_IDLE   = 2'h1,
      DOMC_ACTIVE = 2'h3,
      DOMC_LIMP   = 2'h2
   } domc_mode_t;
endpackage

// file: rtl/domc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of pin levels
module domc_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q; // First stage, read only by second
   // Two flops in series
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else if (ce_i) begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

// file: rtl/domc_mode_ctrl.sv
`timescale 1ns/1ps
`include "domc_consts.svh"
// Behaviour
// [RQ1] Mode from sleep pin, inputs, enables, keep-awake
// [RQ2] Sleep: channels off, registers held reset
// [RQ3] Idle: all channels off
// [RQ4] Idle: no diagnosis
// [RQ5] Idle with logic supply: registers, SPI live
// [RQ6] Active: pin high and input/enable set
// [RQ7] Keep-awake clear: idle when all quiet
// [RQ8] Keep-awake set: stay active
// [RQ9] Logic undervoltage, inputs low: active to idle
// [RQ10] Input high enters active despite empty mapping
// [RQ11] Switch-on request outside active wakes device
// [RQ12] Turn-on adds transition time from other modes; code adds it only on entry from Sleep or Idle, not from Limp Home
// [RQ13] SPI only above logic undervoltage threshold
// [RQ14] Power-up: supply present and pin high
// [RQ15] Power-on from either supply threshold
// [RQ16] Limp Home: pin low, input high, channel on
// [RQ17] Limp Home: SPI reads only
// [RQ18] Sleep when pin and inputs low
module domc_mode_ctrl (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic low_power_request_pin_i, // Pin level, high = awake
   input wire logic [`DOMC_NIN-1:0] direct_channel_inputs_i, // Direct input pins
   input wire logic [`DOMC_NCH-1:0] channel_enable_bits_i, // Enables from registers
   input wire logic keep_awake_bit_i, // Keep-awake register bit
   input wire logic [`DOMC_NCH-1:0] input_channel_map_i, // Input-mapped channels from mapping registers
   input wire logic logic_supply_ok_i, // Logic supply above its threshold
   input wire logic load_supply_ok_i, // Load supply above operating threshold
   input wire logic load_supply_present_i, // Load supply applied at all
   output logic [`DOMC_MODE_W-1:0] mode_o, // Current mode code
   output logic [`DOMC_NCH-1:0] channel_on_o, // Channel drive
   output logic regs_reset_o, // Hold registers at defaults
   output logic spi_enable_o, // SPI transfers accepted
   output logic spi_write_enable_o, // SPI writes accepted
   output logic diag_enable_o, // Diagnosis allowed
   output logic power_on_o, // Internal power-on
   output logic power_up_o // Power-up condition met
);
   logic rst_meta_q; // Reset release stage one
   logic rst_n_q; // Synchronised reset
   logic sleep_pin_s; // Synchronised pin
   logic [`DOMC_NIN-1:0] in_s; // Synchronised inputs
   logic [2:0] sup_s; // Synchronised supply flags
   domc_pkg::domc_mode_t mode_q; // Mode register
   domc_pkg::domc_mode_t mode_d; // Next mode
   logic [31:0] trans_q; // Transition countdown
   logic any_in; // Any input pin high
   logic any_en; // Any enable set
   logic [`DOMC_NCH-1:0] lh_ch; // Channels driven in Limp Home
   logic [`DOMC_NCH-1:0] act_ch; // Channels requested in Active

   // Reset release through two flops
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Pin synchronisers
   domc_sync #(.W(1 + `DOMC_NIN + 3)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_q),
      .ce_i(ce_i),
      .d_i({low_power_request_pin_i, direct_channel_inputs_i,
            logic_supply_ok_i, load_supply_ok_i, load_supply_present_i}),
      .q_o({sleep_pin_s, in_s, sup_s})
   );

   // Request summaries
   always_comb begin
      any_in = |in_s;
      any_en = |channel_enable_bits_i;
      lh_ch = `DOMC_CH_OFF;
      lh_ch[`DOMC_LH_CH_LO +: `DOMC_NIN] = in_s; // see [RQ16]
      act_ch = channel_enable_bits_i | input_channel_map_i;
   end

   // Next mode selection, see [RQ1]
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         domc_pkg::DOMC_SLEEP: begin
            if (sleep_pin_s && any_in) begin
               mode_d = domc_pkg::DOMC_ACTIVE; // see [RQ10] [RQ11]
            end else if (sleep_pin_s) begin
               mode_d = domc_pkg::DOMC_IDLE;
            end else if (any_in) begin
               mode_d = domc_pkg::DOMC_LIMP; // see [RQ16] [RQ11]
            end
         end
         domc_pkg::DOMC_IDLE: begin
            if (!sleep_pin_s) begin
               mode_d = any_in ? domc_pkg::DOMC_LIMP : domc_pkg::DOMC_SLEEP; // see [RQ18]
            end else if (any_in || (any_en && sup_s[2])) begin
               mode_d = domc_pkg::DOMC_ACTIVE; // see [RQ6] [RQ11]
            end
         end
         domc_pkg::DOMC_ACTIVE: begin
            if (!sleep_pin_s) begin
               mode_d = any_in ? domc_pkg::DOMC_LIMP : domc_pkg::DOMC_SLEEP; // see [RQ18]
            end else if (!any_in && !sup_s[2]) begin
               mode_d = domc_pkg::DOMC_IDLE; // see [RQ9]
            end else if (!keep_awake_bit_i && !any_in && !any_en) begin
               mode_d = domc_pkg::DOMC_IDLE; // see [RQ7]
            end
            // Keep-awake holds Active otherwise, see [RQ8]
         end
         domc_pkg::DOMC_LIMP: begin
            if (sleep_pin_s) begin
               mode_d = domc_pkg::DOMC_ACTIVE; // see [RQ11]
            end else if (!any_in) begin
               mode_d = domc_pkg::DOMC_SLEEP; // see [RQ18]
            end
         end
         default: begin
            mode_d = domc_pkg::DOMC_SLEEP;
         end
      endcase
   end

   // Mode register
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode_q <= domc_pkg::DOMC_SLEEP;
      end else if (ce_i) begin
         mode_q <= mode_d;
      end
   end

   // Transition delay on entry to Active or Limp Home from Sleep or Idle
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         trans_q <= 32'h0;
      end else if (ce_i) begin
         if ((mode_d == domc_pkg::DOMC_ACTIVE || mode_d == domc_pkg::DOMC_LIMP) &&
             (mode_q == domc_pkg::DOMC_SLEEP || mode_q == domc_pkg::DOMC_IDLE)) begin
            trans_q <= `DOMC_TRANS_CYC; // see [RQ12]
         end else if (trans_q != 32'h0) begin
            trans_q <= trans_q - 32'h1;
         end
      end
   end

   // Channel drive per mode
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         channel_on_o <= `DOMC_CH_OFF;
      end else if (ce_i) begin
         if (trans_q != 32'h0) begin
            channel_on_o <= `DOMC_CH_OFF; // see [RQ12]
         end else if (mode_q == domc_pkg::DOMC_ACTIVE) begin
            // Register control needs logic supply
            channel_on_o <= sup_s[2] ? act_ch : (input_channel_map_i & act_ch);
         end else if (mode_q == domc_pkg::DOMC_LIMP && (sup_s[2] || sup_s[0])) begin
            channel_on_o <= lh_ch; // see [RQ16]
         end else begin
            channel_on_o <= `DOMC_CH_OFF; // see [RQ2] [RQ3]
         end
      end
   end

   // Register and SPI gating
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         regs_reset_o <= 1'b1;
         spi_enable_o <= 1'b0;
         spi_write_enable_o <= 1'b0;
         diag_enable_o <= 1'b0;
         mode_o <= 2'h0;
      end else if (ce_i) begin
         mode_o <= mode_q;
         regs_reset_o <= (mode_q == domc_pkg::DOMC_SLEEP) || !sup_s[2]; // see [RQ2] [RQ13]
         spi_enable_o <= (mode_q != domc_pkg::DOMC_SLEEP) && sup_s[2]; // see [RQ5] [RQ13]
         spi_write_enable_o <= (mode_q == domc_pkg::DOMC_IDLE || mode_q == domc_pkg::DOMC_ACTIVE)
                               && sup_s[2]; // see [RQ17]
         diag_enable_o <= (mode_q == domc_pkg::DOMC_ACTIVE) || (mode_q == domc_pkg::DOMC_LIMP); // see [RQ4]
      end
   end

   // Power-on and power-up flags
   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         power_on_o <= 1'b0;
         power_up_o <= 1'b0;
      end else if (ce_i) begin
         power_on_o <= sup_s[1] || sup_s[2]; // see [RQ15]
         power_up_o <= (sup_s[0] || sup_s[2]) && (any_in || sleep_pin_s); // see [RQ14]
      end
   end
endmodule

// file: verification/domc_mode_ctrl_monitor.sv
`timescale 1ns/1ps
// Watches mode, channel and access outputs of the mode controller
module domc_mode_ctrl_monitor (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic low_power_request_pin_i,
   input wire logic [1:0] direct_channel_inputs_i,
   input wire logic logic_supply_ok_i,
   input wire logic [1:0] mode_o,
   input wire logic [3:0] channel_on_o,
   input wire logic regs_reset_o,
   input wire logic spi_enable_o,
   input wire logic spi_write_enable_o,
   input wire logic diag_enable_o,
   input wire logic power_on_o,
   input wire logic power_up_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   // Arrival in active from a mode that is not limp home
   sequence s_woke;
      $changed(mode_o) && mode_o == domc_pkg::DOMC_ACTIVE && $past(mode_o) != domc_pkg::DOMC_LIMP;
   endsequence
   a_sleep_chan_off: assert property (mode_o == domc_pkg::DOMC_SLEEP |-> channel_on_o == 4'h0)
      else $error("channel driven in sleep");
   a_sleep_regs_held: assert property (mode_o == domc_pkg::DOMC_SLEEP |-> regs_reset_o)
      else $error("registers live in sleep");
   a_idle_chan_off: assert property (mode_o == domc_pkg::DOMC_IDLE |-> channel_on_o == 4'h0)
      else $error("channel driven in idle");
   a_idle_no_diag: assert property (mode_o == domc_pkg::DOMC_IDLE |-> !diag_enable_o)
      else $error("diagnosis in idle");
   a_limp_no_write: assert property (mode_o == domc_pkg::DOMC_LIMP |-> !spi_write_enable_o)
      else $error("write allowed in limp home");
   a_uv_spi_off: assert property (!logic_supply_ok_i [*6] |-> !spi_enable_o && regs_reset_o)
      else $error("spi live without logic supply");
   a_power_on_set: assert property (logic_supply_ok_i [*8] |-> power_on_o)
      else $error("power-on missing");
   a_power_up_set: assert property ((logic_supply_ok_i && low_power_request_pin_i) [*8] |-> power_up_o)
      else $error("power-up condition missing");
   a_wake_to_active: assert property ((low_power_request_pin_i && direct_channel_inputs_i != 2'h0) [*8]
      |-> mode_o == domc_pkg::DOMC_ACTIVE)
      else $error("input did not wake to active");
   a_limp_entry_seen: assert property ((!low_power_request_pin_i && logic_supply_ok_i
      && direct_channel_inputs_i != 2'h0) [*8] |-> mode_o == domc_pkg::DOMC_LIMP)
      else $error("no limp home entry");
   a_fall_to_sleep: assert property ((!low_power_request_pin_i && direct_channel_inputs_i == 2'h0) [*8]
      |-> mode_o == domc_pkg::DOMC_SLEEP)
      else $error("no fall back to sleep");
   a_turn_on_delay: assert property (s_woke |-> (channel_on_o == 4'h0) [*8])
      else $error("channel on before transition time");
endmodule

// file: verification/domc_host_model.sv
`timescale 1ns/1ps
// Host controller: pin levels and register bits
module domc_host_model (
   input wire logic clk_sys_i,
   output logic low_power_request_pin_o,
   output logic [1:0] direct_channel_inputs_o,
   output logic [3:0] channel_enable_bits_o,
   output logic keep_awake_bit_o,
   output logic [3:0] input_channel_map_o
);
   // All quiet from time zero, mapping empty
   initial begin
      {low_power_request_pin_o, direct_channel_inputs_o, channel_enable_bits_o, keep_awake_bit_o} = 8'h00;
      input_channel_map_o = 4'h0;
   end
   // One command, launched at a falling edge
   task automatic drive(input logic p, input logic [1:0] i, input logic [3:0] e, input logic k);
      @(negedge clk_sys_i);
      low_power_request_pin_o <= p;
      direct_channel_inputs_o <= i;
      channel_enable_bits_o <= e;
      keep_awake_bit_o <= k;
   endtask
endmodule

// file: verification/driver_operating_mode_control_tb.sv
`timescale 1ns/1ps
module driver_operating_mode_control_tb;
   logic clk_sys_i = 1'b0; // 50 ns clock
   logic rstn_i = 1'b0; // Reset, active low
   logic lso = 1'b1; // Logic supply good
   logic pin, keep;
   logic [1:0] din, mode;
   logic [3:0] en, map, ch, r;
   logic spi_en, spi_wr;
   logic [7:0] notes[$]; // Expected {mode, channels, spi, write}
   logic [7:0] w;
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   event seen;
   domc_host_model host (.clk_sys_i(clk_sys_i), .low_power_request_pin_o(pin), .direct_channel_inputs_o(din),
      .channel_enable_bits_o(en), .keep_awake_bit_o(keep), .input_channel_map_o(map));
   domc_mode_ctrl dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1), .low_power_request_pin_i(pin),
      .direct_channel_inputs_i(din), .channel_enable_bits_i(en), .keep_awake_bit_i(keep),
      .input_channel_map_i(map), .logic_supply_ok_i(lso), .load_supply_ok_i(1'b1),
      .load_supply_present_i(1'b1), .mode_o(mode), .channel_on_o(ch), .regs_reset_o(),
      .spi_enable_o(spi_en), .spi_write_enable_o(spi_wr), .diag_enable_o(), .power_on_o(), .power_up_o());
   // Clock
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Drive one command, let it settle, note the expectation
   task automatic step(input string nm, input logic p, input logic [1:0] i, input logic [3:0] e,
      input logic k, input logic [7:0] want);
      host.drive(p, i, e, k);
      repeat (40) @(negedge clk_sys_i);
      notes.push_back(want);
      -> seen;
      #1 $display("test %s done", nm);
   endtask
   // Compare outputs with the oldest note
   initial begin
      forever begin
         @(seen);
         w = notes.pop_front();
         total_checks++;
         if ({mode, ch, spi_en, spi_wr} !== w) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, {mode, ch, spi_en, spi_wr}, w);
         end
      end
   end
   // Hang guard
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // Main sequence
   initial begin
      void'($urandom(32'he016ad07));
      r = 4'($urandom_range(15, 1));
      repeat (4) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      step("idle", 1, 0, 0, 0, {domc_pkg::DOMC_IDLE, 4'h0, 2'h3});
      step("enable wake", 1, 0, r, 0, {domc_pkg::DOMC_ACTIVE, r, 2'h3});
      step("keep awake", 1, 0, 0, 1, {domc_pkg::DOMC_ACTIVE, 4'h0, 2'h3});
      step("quiet drop", 1, 0, 0, 0, {domc_pkg::DOMC_IDLE, 4'h0, 2'h3});
      step("input wake", 1, 1, 0, 0, {domc_pkg::DOMC_ACTIVE, 4'h0, 2'h3});
      step("limp low", 0, 1, 0, 0, {domc_pkg::DOMC_LIMP, 4'h4, 2'h2});
      step("limp high", 0, 2, 0, 0, {domc_pkg::DOMC_LIMP, 4'h8, 2'h2});
      step("sleep", 0, 0, 0, 0, {domc_pkg::DOMC_SLEEP, 4'h0, 2'h0});
      step("rewake", 1, 0, r, 0, {domc_pkg::DOMC_ACTIVE, r, 2'h3});
      lso = 1'b0;
      step("logic uv", 1, 0, r, 0, {domc_pkg::DOMC_IDLE, 4'h0, 2'h0});
      wrap_up();
   end
endmodule
bind domc_mode_ctrl domc_mode_ctrl_monitor mon (.clk_sys_i, .rstn_i, .low_power_request_pin_i,
   .direct_channel_inputs_i, .logic_supply_ok_i, .mode_o, .channel_on_o, .regs_reset_o, .spi_enable_o,
   .spi_write_enable_o, .diag_enable_o, .power_on_o, .power_up_o);
